// *** core/rx_check_device.sv ***
// Receiver lane check, sample check and link parameter capture
// Functional notes
// - Read bits 23:16 of selected lane count
// - Per-lane pass bits, reset to all ones
// - Bits 5:4 pick checked sample
// - Bits 3:2 pick checked channel
// - Writing one clears stored check result
// - Comparison runs only while enable set
// - Two bytes form 16-bit expected sample
// - Fail bit: zero on match, one differ
// - Software writes 0x01 to interface setup
// - Invert mask bit flips its logical lane
// - Capture device identifier from lane 0
// - Capture adjust count and bank; count zero
// - Capture direction and phase flags; zero sent
// - Capture five-bit lane identifier
// - Capture lanes-minus-one parameter
// - Capture octets-per-frame-minus-one; valid codes only
// - Three-bit field selects counted lane
// - 24-bit threshold over three bytes, LSB first
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rx_check_device
	import rx_check_pkg::*;
(
	input wire logic clock_in,
	input wire logic arst_n_in,
	rx_check_if.device link,
	input wire logic [191:0] lane_counts_in,
	input wire logic [63:0] lane_data_in,
	input wire logic [255:0] samples_in,
	output logic [63:0] lane_data_out,
	output logic [7:0] if_setup_out
);
	typedef struct packed {
		logic [7:0] rdata;
		logic [7:0] pass;
		logic [2:0] cnt_sel;
		logic [23:0] limit;
		logic [1:0] sample_sel;
		logic [1:0] chan_sel;
		logic enable;
		logic [15:0] expected;
		logic mismatch;
		logic [7:0] if_setup;
		logic [7:0] invert;
		logic [7:0] dev_ident;
		logic [7:0] adj_bank;
		logic [7:0] lane_ident;
		logic [7:0] scr_lanes;
		logic [7:0] octets;
		logic [63:0] lane_data;
	} state_s;

	state_s state_reg;
	state_s state_next;

	function automatic logic [23:0] lane_count(input logic [191:0] all, input logic [2:0] idx);
		lane_count = all[idx*24 +: 24];
	endfunction : lane_count

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [23:0] sel_count;
		logic [15:0] chosen;
		sel_count = lane_count(lane_counts_in, state_reg.cnt_sel);
		chosen = samples_in[{state_reg.chan_sel, state_reg.sample_sel}*16 +: 16];
		state_next = state_reg;
		for (int i = 0; i < 8; i++) begin
			state_next.pass[i] = lane_count(lane_counts_in, 3'(i)) < state_reg.limit;
			state_next.lane_data[i*8 +: 8] = lane_data_in[i*8 +: 8] ^
				{8{state_reg.invert[i]}};
		end
		if (link.cfg_valid) begin
			state_next.dev_ident = link.cfg_dev_ident;
			state_next.adj_bank = link.cfg_adj_bank;
			state_next.lane_ident = {1'b0, link.cfg_lane_ident[6:0]};
			state_next.scr_lanes = {link.cfg_scr_lanes[7], 2'b00, link.cfg_scr_lanes[4:0]};
			state_next.octets = link.cfg_octets;
		end
		if (link.reg_wr) begin
			unique case (link.reg_addr)
				OFF_CNT_SELECT: state_next.cnt_sel = link.reg_wdata[SEL_LANE_LSB +: 3];
				OFF_LIMIT_LOW: state_next.limit[7:0] = link.reg_wdata;
				OFF_LIMIT_MID: state_next.limit[15:8] = link.reg_wdata;
				OFF_LIMIT_HIGH: state_next.limit[23:16] = link.reg_wdata;
				OFF_CHECK_CTRL: begin
					state_next.sample_sel = link.reg_wdata[SAMPLE_SEL_LSB +: 2];
					state_next.chan_sel = link.reg_wdata[CHAN_SEL_LSB +: 2];
					state_next.enable = link.reg_wdata[ENABLE_BIT];
					if (link.reg_wdata[CLEAR_BIT]) begin
						state_next.mismatch = 1'b0;
					end
				end
				OFF_REF_LOW: state_next.expected[7:0] = link.reg_wdata;
				OFF_REF_HIGH: state_next.expected[15:8] = link.reg_wdata;
				OFF_IF_SETUP: state_next.if_setup = link.reg_wdata;
				OFF_LANE_INVERT: state_next.invert = link.reg_wdata;
				default: ;
			endcase
		end
		// A new mismatch wins over a clear in the same cycle
		if (state_reg.enable && chosen != state_reg.expected) begin
			state_next.mismatch = 1'b1;
		end
		unique case (link.reg_addr)
			OFF_ERR_HIGH: state_next.rdata = sel_count[23:16];
			OFF_PASS_FLAGS: state_next.rdata = state_reg.pass;
			OFF_CNT_SELECT: state_next.rdata = {1'b0, state_reg.cnt_sel, 4'h0};
			OFF_LIMIT_LOW: state_next.rdata = state_reg.limit[7:0];
			OFF_LIMIT_MID: state_next.rdata = state_reg.limit[15:8];
			OFF_LIMIT_HIGH: state_next.rdata = state_reg.limit[23:16];
			OFF_CHECK_CTRL: state_next.rdata = {2'b00, state_reg.sample_sel, state_reg.chan_sel,
				1'b0, state_reg.enable};
			OFF_REF_LOW: state_next.rdata = state_reg.expected[7:0];
			OFF_REF_HIGH: state_next.rdata = state_reg.expected[15:8];
			OFF_CHECK_RESULT: state_next.rdata = {7'h00, state_reg.mismatch};
			OFF_IF_SETUP: state_next.rdata = state_reg.if_setup;
			OFF_LANE_INVERT: state_next.rdata = state_reg.invert;
			OFF_DEV_IDENT: state_next.rdata = state_reg.dev_ident;
			OFF_ADJ_BANK: state_next.rdata = state_reg.adj_bank;
			OFF_LANE_IDENT: state_next.rdata = state_reg.lane_ident;
			OFF_SCR_LANES: state_next.rdata = state_reg.scr_lanes;
			OFF_OCTETS: state_next.rdata = state_reg.octets;
			default: state_next.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= '0;
			state_reg.pass <= PASS_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign link.reg_rdata = state_reg.rdata;
	assign lane_data_out = state_reg.lane_data;
	assign if_setup_out = state_reg.if_setup;
endmodule : rx_check_device
`default_nettype wire

// *** core/rx_check_host.sv ***
// Host end: APB registers drive device register access and link parameters
`timescale 1ns/1ps
`default_nettype none
module rx_check_host
	import rx_check_pkg::*;
(
	input wire logic clock_in,
	input wire logic arst_n_in,
	rx_check_if.host link,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic irq_out
);
	typedef enum logic [1:0] {IDLE, WAIT, CAPTURE} phase_e;
	typedef struct packed {
		phase_e phase;
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic [7:0] rdata;
		logic [1:0] status;
		logic [1:0] mask;
		logic [39:0] params;
		logic cfg_valid;
	} state_s;

	state_s state_reg;
	state_s state_next;
	logic access;

	assign access = psel_in && penable_in;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		state_next.wr = 1'b0;
		state_next.rd = 1'b0;
		state_next.cfg_valid = 1'b0;
		unique case (state_reg.phase)
			IDLE: ;
			WAIT: state_next.phase = CAPTURE;
			CAPTURE: begin
				state_next.rdata = link.reg_rdata;
				state_next.status[ST_DONE_BIT] = 1'b1;
				state_next.phase = IDLE;
			end
		endcase
		if (access && pwrite_in) begin
			unique case (paddr_in)
				APB_CMD: begin
					// Bit 12 write, bit 13 read, 11:0 address
					state_next.addr = pwdata_in[11:0];
					state_next.wr = pwdata_in[12];
					state_next.rd = pwdata_in[13];
					if (pwdata_in[13]) begin
						state_next.phase = WAIT;
					end
				end
				APB_WDATA: state_next.wdata = pwdata_in[7:0];
				APB_MASK: state_next.mask = pwdata_in[1:0];
				APB_PARAMS: begin
					state_next.params = {pwdata_in[31:0], 8'h00};
					state_next.params[15:12] = 4'h0;
					state_next.params[22:21] = 2'b00;
					state_next.cfg_valid = 1'b1;
					if (pwdata_in[31:24] != 8'h00 && pwdata_in[31:24] != 8'h01
						&& pwdata_in[31:24] != 8'h03) begin
						state_next.params[39:32] = 8'h00;
						state_next.status[ST_BAD_PARAM_BIT] = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (access && !pwrite_in && paddr_in == APB_STATUS) begin
			state_next.status = '0;
			if (state_reg.phase == CAPTURE) begin
				state_next.status[ST_DONE_BIT] = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= '0;
			state_reg.phase <= IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_comb begin
		unique case (paddr_in)
			APB_WDATA: prdata_out = {24'h000000, state_reg.wdata};
			APB_RDATA: prdata_out = {24'h000000, state_reg.rdata};
			APB_STATUS: prdata_out = {30'h00000000, state_reg.status};
			APB_MASK: prdata_out = {30'h00000000, state_reg.mask};
			default: prdata_out = 32'h00000000;
		endcase
	end

	assign pready_out = 1'b1;
	assign pslverr_out = 1'b0;
	assign irq_out = |(state_reg.status & state_reg.mask);
	assign link.reg_wr = state_reg.wr;
	assign link.reg_rd = state_reg.rd;
	assign link.reg_addr = state_reg.addr;
	assign link.reg_wdata = state_reg.wdata;
	assign link.cfg_valid = state_reg.cfg_valid;
	assign link.cfg_dev_ident = state_reg.params[7:0];
	assign link.cfg_adj_bank = state_reg.params[15:8];
	assign link.cfg_lane_ident = state_reg.params[23:16];
	assign link.cfg_scr_lanes = state_reg.params[31:24];
	assign link.cfg_octets = state_reg.params[39:32];
endmodule : rx_check_host
`default_nettype wire

// *** core/rx_check_if.sv ***
// Register port and link-parameter path between the two ends
`timescale 1ns/1ps
`default_nettype none
interface rx_check_if;
	logic reg_wr;
	logic reg_rd;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic cfg_valid;
	logic [7:0] cfg_dev_ident;
	logic [7:0] cfg_adj_bank;
	logic [7:0] cfg_lane_ident;
	logic [7:0] cfg_scr_lanes;
	logic [7:0] cfg_octets;
	modport device (input reg_wr, reg_rd, reg_addr, reg_wdata, cfg_valid, cfg_dev_ident,
		cfg_adj_bank, cfg_lane_ident, cfg_scr_lanes, cfg_octets, output reg_rdata);
	modport host (output reg_wr, reg_rd, reg_addr, reg_wdata, cfg_valid, cfg_dev_ident,
		cfg_adj_bank, cfg_lane_ident, cfg_scr_lanes, cfg_octets, input reg_rdata);
endinterface : rx_check_if
`default_nettype wire

// *** core/rx_check_pkg.sv ***
// Shared constants for the lane check and link capture block
package rx_check_pkg;
	localparam logic [11:0] OFF_ERR_HIGH = 12'h31C;
	localparam logic [11:0] OFF_PASS_FLAGS = 12'h31D;
	localparam logic [11:0] OFF_CHECK_CTRL = 12'h32C;
	localparam logic [11:0] OFF_REF_LOW = 12'h32D;
	localparam logic [11:0] OFF_REF_HIGH = 12'h32E;
	localparam logic [11:0] OFF_CHECK_RESULT = 12'h32F;
	localparam logic [11:0] OFF_IF_SETUP = 12'h333;
	localparam logic [11:0] OFF_LANE_INVERT = 12'h334;
	localparam logic [11:0] OFF_DEV_IDENT = 12'h400;
	localparam logic [11:0] OFF_ADJ_BANK = 12'h401;
	localparam logic [11:0] OFF_LANE_IDENT = 12'h402;
	localparam logic [11:0] OFF_SCR_LANES = 12'h403;
	localparam logic [11:0] OFF_OCTETS = 12'h404;
	localparam logic [11:0] OFF_CNT_SELECT = 12'h316;
	localparam logic [11:0] OFF_LIMIT_LOW = 12'h317;
	localparam logic [11:0] OFF_LIMIT_MID = 12'h318;
	localparam logic [11:0] OFF_LIMIT_HIGH = 12'h319;
	localparam int SEL_LANE_LSB = 4;
	localparam int SAMPLE_SEL_LSB = 4;
	localparam int CHAN_SEL_LSB = 2;
	localparam int CLEAR_BIT = 1;
	localparam int ENABLE_BIT = 0;
	localparam logic [7:0] PASS_RESET = 8'hFF;
	localparam logic [7:0] IF_SETUP_VALUE = 8'h01;
	// Host-side APB register map
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_WDATA = 8'h04;
	localparam logic [7:0] APB_RDATA = 8'h08;
	localparam logic [7:0] APB_STATUS = 8'h0C;
	localparam logic [7:0] APB_MASK = 8'h10;
	localparam logic [7:0] APB_PARAMS = 8'h14;
	localparam int ST_DONE_BIT = 0;
	localparam int ST_BAD_PARAM_BIT = 1;
endpackage : rx_check_pkg

// *** tb/rx_check_asserts.sv ***
// Interface checks between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module rx_check_asserts
	import rx_check_pkg::*;
(
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic reg_wr,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic cfg_valid,
	input wire logic [7:0] cfg_adj_bank,
	input wire logic [7:0] cfg_lane_ident,
	input wire logic [7:0] cfg_octets
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);
	////////////////////////////////////////
	sequence wr_then(logic [11:0] a);
		reg_wr && reg_addr == a ##1 reg_addr == a;
	endsequence
	sequence cap_then(logic [11:0] a);
		cfg_valid ##1 reg_addr == a;
	endsequence
	////////////////////////////////////////
	adj_count_zero_a: assert property (cfg_valid |-> cfg_adj_bank[7:4] == 4'h0)
		else $error("adjust count sent nonzero");
	adj_flags_zero_a: assert property (cfg_valid |-> cfg_lane_ident[6:5] == 2'h0)
		else $error("adjust flags sent nonzero");
	octets_legal_a: assert property (cfg_valid |-> cfg_octets inside {8'h00, 8'h01, 8'h03})
		else $error("illegal octets code sent");
	octets_capture_a: assert property (cap_then(OFF_OCTETS) |=> reg_rdata == $past(cfg_octets, 2))
		else $error("octets code not captured");
	ref_low_write_a: assert property (wr_then(OFF_REF_LOW) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("expected sample low byte lost");
	ref_high_write_a: assert property (wr_then(OFF_REF_HIGH) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("expected sample high byte lost");
	invert_write_a: assert property (wr_then(OFF_LANE_INVERT) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("invert mask lost");
	limit_write_a: assert property (wr_then(OFF_LIMIT_LOW) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("threshold low byte lost");
	result_reserved_a: assert property (reg_addr == OFF_CHECK_RESULT |=> reg_rdata[7:1] == 7'h00)
		else $error("result reserved bits set");
endmodule : rx_check_asserts
`default_nettype wire

// *** tb/serial_link_rx_test_and_config_capture_tb.sv ***
// Bench driving both link ends over APB
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module serial_link_rx_test_and_config_capture_tb;
	import rx_check_pkg::*;
	logic clock_in, arst_n_in, psel, penable, pwrite, pready, irq;
	logic [7:0] paddr, v, if_setup;
	logic [31:0] pwdata, prdata, rd;
	logic [191:0] counts;
	logic [63:0] ldata, lout;
	logic [255:0] samples;
	int n_errors = 0;
	int tests_run = 0;
	rx_check_if link();
	rx_check_device rx_check_device_i(.clock_in(clock_in), .arst_n_in(arst_n_in), .link(link),
		.lane_counts_in(counts), .lane_data_in(ldata), .samples_in(samples),
		.lane_data_out(lout), .if_setup_out(if_setup));
	rx_check_host rx_check_host_i(.clock_in(clock_in), .arst_n_in(arst_n_in), .link(link),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(),
		.irq_out(irq));
	rx_check_asserts rx_check_asserts_i(.clock_in(clock_in), .arst_n_in(arst_n_in),
		.reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.reg_rdata(link.reg_rdata), .cfg_valid(link.cfg_valid), .cfg_adj_bank(link.cfg_adj_bank),
		.cfg_lane_ident(link.cfg_lane_ident), .cfg_octets(link.cfg_octets));
	////////////////////////////////////////
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		@(posedge clock_in);
		for (k = 0; k < 8 && pready !== 1'b1; k++)
			@(posedge clock_in);
		if (k == 8) begin
			n_errors++;
			summarize();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic dwr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, APB_WDATA, {24'h0, d});
		apb(1'b1, APB_CMD, {18'h0, 2'b01, a});
		repeat (3) @(posedge clock_in);
	endtask : dwr
	task automatic drd(input logic [11:0] a, output logic [7:0] d);
		int k;
		apb(1'b1, APB_CMD, {18'h0, 2'b10, a});
		rd = '0;
		for (k = 0; k < 10 && rd[ST_DONE_BIT] !== 1'b1; k++)
			apb(1'b0, APB_STATUS, 32'h0);
		if (k == 10) begin
			n_errors++;
			summarize();
		end
		apb(1'b0, APB_RDATA, 32'h0);
		d = rd[7:0];
	endtask : drd
	////////////////////////////////////////
	task automatic t_setup();
		`CHK("setup reset", 8'h00, if_setup)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		dwr(OFF_IF_SETUP, IF_SETUP_VALUE);
		`CHK("setup byte", IF_SETUP_VALUE, if_setup)
		drd(OFF_LANE_INVERT, v);
		`CHK("invert reset", 8'h00, v)
		ldata <= 64'h0123456789ABCDEF;
		dwr(OFF_LANE_INVERT, 8'hA5);
		`CHK("lane data", 64'hFE23BA678954CD10, lout)
		$display("setup test done");
	endtask : t_setup
	task automatic t_prbs();
		logic [191:0] c;
		for (int i = 0; i < 8; i++)
			c[i*24 +: 24] = (i == 5) ? 24'hAB1234 : (i < 4) ? 24'h012344 : 24'h012345;
		counts <= c;
		dwr(OFF_LIMIT_LOW, 8'h45);
		dwr(OFF_LIMIT_MID, 8'h23);
		dwr(OFF_LIMIT_HIGH, 8'h01);
		dwr(OFF_CNT_SELECT, 8'h50);
		drd(OFF_ERR_HIGH, v);
		`CHK("count high", 8'hAB, v)
		drd(OFF_PASS_FLAGS, v);
		`CHK("pass flags", 8'h0F, v)
		$display("error count test done");
	endtask : t_prbs
	task automatic t_check();
		logic [255:0] s;
		for (int k = 0; k < 16; k++)
			s[k*16 +: 16] = {8'(k), 8'h3C};
		samples <= s;
		dwr(OFF_REF_LOW, 8'h3C);
		dwr(OFF_REF_HIGH, 8'h0B);
		dwr(OFF_CHECK_CTRL, 8'h39);
		drd(OFF_CHECK_RESULT, v);
		`CHK("match", 8'h00, v)
		dwr(OFF_REF_HIGH, 8'h0C);
		drd(OFF_CHECK_RESULT, v);
		`CHK("mismatch", 8'h01, v)
		dwr(OFF_REF_HIGH, 8'h0B);
		drd(OFF_CHECK_RESULT, v);
		`CHK("sticky", 8'h01, v)
		dwr(OFF_CHECK_CTRL, 8'h3B);
		drd(OFF_CHECK_RESULT, v);
		`CHK("cleared", 8'h00, v)
		dwr(OFF_CHECK_CTRL, 8'h38);
		dwr(OFF_REF_HIGH, 8'h0C);
		drd(OFF_CHECK_RESULT, v);
		`CHK("disabled", 8'h00, v)
		$display("sample check test done");
	endtask : t_check
	task automatic t_params();
		logic [11:0] ad[5] = '{OFF_DEV_IDENT, OFF_ADJ_BANK, OFF_LANE_IDENT, OFF_SCR_LANES, OFF_OCTETS};
		logic [7:0] ex[5] = '{8'h00, 8'h07, 8'h15, 8'h83, 8'h03};
		apb(1'b1, APB_MASK, 32'h2);
		apb(1'b1, APB_PARAMS, 32'h02E375F7);
		repeat (4) @(posedge clock_in);
		`CHK("irq raised", 1'b1, irq)
		apb(1'b0, APB_STATUS, 32'h0);
		`CHK("bad octets", 1'b1, rd[ST_BAD_PARAM_BIT])
		@(posedge clock_in);
		`CHK("irq cleared", 1'b0, irq)
		drd(OFF_OCTETS, v);
		`CHK("octets refused", 8'h00, v)
		apb(1'b1, APB_MASK, 32'h0);
		apb(1'b1, APB_PARAMS, 32'h02E375F7);
		repeat (4) @(posedge clock_in);
		`CHK("irq masked", 1'b0, irq)
		apb(1'b1, APB_PARAMS, 32'h03E375F7);
		for (int i = 0; i < 5; i++) begin
			drd(ad[i], v);
			`CHK("captured", ex[i], v)
		end
		$display("link parameter test done");
	endtask : t_params
	////////////////////////////////////////
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	initial begin
		arst_n_in = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, counts, ldata, samples} = '0;
		repeat (4) @(posedge clock_in);
		arst_n_in <= 1'b1;
		t_setup();
		t_prbs();
		t_check();
		t_params();
		summarize();
	end
endmodule : serial_link_rx_test_and_config_capture_tb
`default_nettype wire
